// [hdl/port_a_ctrl.v]
/*
  port A with analog selection and oscillator-pin sharing, plus the three
  peripheral open-drain control registers, behind an ahb-lite slave.
  assumes a single ahb-lite master, word transfers only; pad inputs are
  asynchronous; peripheral data/drive inputs come from hclk logic.
*/
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
// Notes on behaviour
// - first register: serial1, capture2/1, serial2 open-drain
// - unimplemented open-drain bits ignore writes, read zero
// - second register: capture units three to ten
// - small variant lacks capture ten, nine enables
// - third register: uart two, uart one open-drain
// - third register bit zero gates pulse-delay input
// - open-drain bits read/write, reset to zero
// - analog select set means analog, clear digital
// - eight-bit bidirectional port, direction and latch
// - pin four schmitt, others ttl, cmos drivers
// - pins five, three..zero are analog capable
// - direction bits still steer analog pins
// - reset: analog pins read zero, pin four digital
// - external oscillator: pins six, seven read zero
// - internal oscillator frees pins six, seven
// - pin five feeds timer1 clock, timer3 gate
// - port read gives pins, write sets latch
// - direction one is input, zero drives latch
`timescale 1ns/10ps
`default_nettype none
`include "port_a_defs.vh"

module port_a_ctrl #(
    parameter SMALL_VARIANT = 0
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    input  wire        osc_internal_cfg,
    input  wire [7:0]  port_a_pin_in,
    output reg  [7:0]  port_a_pin_out,
    output reg  [7:0]  port_a_pin_oe_n,
    output reg  [7:0]  port_a_analog_sel,
    output reg         timer1_clk_in,
    output reg         timer3_gate_in,
    input  wire        port_f_pin_one_in,
    output reg         pulse_delay_in,
    input  wire [13:0] periph_data,
    input  wire [13:0] periph_drive,
    output reg  [13:0] periph_pad_out,
    output reg  [13:0] periph_pad_oe_n
);

    // ==========================================================
    // declarations
    reg  [7:0]  od_serial_capture_q;
    reg  [7:0]  od_capture_units_q;
    reg  [7:0]  od_uart_pulse_q;
    reg  [7:0]  analog_sel_q;
    reg  [7:0]  latch_q;
    reg  [7:0]  direction_q;
    reg         osc_internal_q;
    reg         cfg_taken_q;
    reg         wr_pend_q;
    reg         rd_pend_q;
    reg  [7:0]  addr_q;
    reg  [7:0]  rdata;
    wire [13:0] od_en;
    reg  [7:0]  digital_mask;
    wire [8:0]  pins_sync;
    wire [7:0]  pa_sync;
    wire        pf1_sync;
    wire        take;
    wire [7:0]  capture_mask;
    wire [7:0]  wbyte;
    genvar      u;
    genvar      p;

    // bit-wise copy of the analog-select reset value for the per-pin flops
    localparam [7:0] ASEL_RESET = `RST_ANALOG_SELECT;

    assign capture_mask = (SMALL_VARIANT != 0) ? `MASK_OD_CAPTURE_SMALL
                                               : `MASK_OD_CAPTURE_FULL;
    assign wbyte = hwdata[7:0];
    assign take  = hsel & hready & htrans[1];

    // ==========================================================
    // pad input synchronisers
    sync_bits #(
        .WIDTH (9)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in ({port_f_pin_one_in, port_a_pin_in}),
        .sync_out (pins_sync)
    );

    assign pa_sync  = pins_sync[7:0];
    assign pf1_sync = pins_sync[8];

    // ==========================================================
    // oscillator mode, caught once after reset release
    // config is static; sampling after release avoids a port value in reset
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            osc_internal_q <= 1'b0;
            cfg_taken_q    <= 1'b0;
        end
        else if (!cfg_taken_q)
        begin
            osc_internal_q <= osc_internal_cfg;
            cfg_taken_q    <= 1'b1;
        end
    end

    // ==========================================================
    // ahb-lite address and data phase
    // reads take one wait state so a write just before is seen
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h00000000;
            hresp     <= 1'b0;
        end
        else
        begin
            hresp <= 1'b0;
            if (rd_pend_q)
            begin
                hrdata    <= {24'h000000, rdata};
                hreadyout <= 1'b1;
                rd_pend_q <= 1'b0;
            end
            else if (hready)
            begin
                wr_pend_q <= take & hwrite;
                rd_pend_q <= take & ~hwrite;
                if (take)
                begin
                    addr_q <= haddr[7:0];
                end
                if (take & ~hwrite)
                begin
                    hreadyout <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // register file
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            od_serial_capture_q <= `RST_OD;
            od_capture_units_q  <= `RST_OD;
            od_uart_pulse_q     <= `RST_OD;
            analog_sel_q        <= `RST_ANALOG_SELECT;
            latch_q             <= `RST_LATCH;
            direction_q         <= `RST_DIRECTION;
        end
        else if (wr_pend_q)
        begin
            case (addr_q)
                `OFS_OD_SERIAL_CAPTURE:
                    od_serial_capture_q <= wbyte & `MASK_OD_SERIAL_CAPTURE;
                `OFS_OD_CAPTURE_UNITS:
                    od_capture_units_q <= wbyte & capture_mask;
                `OFS_OD_UART_PULSE_DELAY:
                    od_uart_pulse_q <= wbyte & `MASK_OD_UART_PULSE_DELAY;
                `OFS_ANALOG_SELECT:
                    analog_sel_q <= wbyte & `MASK_ANALOG_CAPABLE;
                `OFS_PORT_A_PIN_LEVELS:
                    latch_q <= wbyte;
                `OFS_PORT_A_OUTPUT_LATCH:
                    latch_q <= wbyte;
                `OFS_PORT_A_DIRECTION:
                    direction_q <= wbyte;
                default:
                    latch_q <= latch_q;
            endcase
        end
    end

    // ==========================================================
    // read mux
    always @*
    begin
        // pins six and seven belong to the oscillator unless internal mode
        digital_mask = osc_internal_q ? 8'hff : ~`MASK_OSC_PINS;
        case (addr_q)
            `OFS_OD_SERIAL_CAPTURE:
                rdata = od_serial_capture_q;
            `OFS_OD_CAPTURE_UNITS:
                rdata = od_capture_units_q;
            `OFS_OD_UART_PULSE_DELAY:
                rdata = od_uart_pulse_q;
            `OFS_ANALOG_SELECT:
                rdata = analog_sel_q;
            `OFS_PORT_A_PIN_LEVELS:
                rdata = pa_sync & ~analog_sel_q & digital_mask;
            `OFS_PORT_A_OUTPUT_LATCH:
                rdata = latch_q & digital_mask;
            `OFS_PORT_A_DIRECTION:
                rdata = direction_q & digital_mask;
            default:
                rdata = 8'h00;
        endcase
    end

    // ==========================================================
    // port A pads
    // thresholds (schmitt on pin four, ttl elsewhere) live in the pad cell
    // analog select does not touch the driver: software must keep
    // the direction bit set on analog pins or the pad fights the source
    generate
        for (p = 0; p < 8; p = p + 1)
        begin : g_pin
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    port_a_pin_out[p]    <= 1'b0;
                    port_a_pin_oe_n[p]   <= 1'b1;
                    port_a_analog_sel[p] <= ASEL_RESET[p];
                end
                else
                begin
                    port_a_pin_out[p]    <= latch_q[p] & digital_mask[p];
                    port_a_pin_oe_n[p]   <= direction_q[p] | ~digital_mask[p];
                    port_a_analog_sel[p] <= analog_sel_q[p];
                end
            end
        end
    endgenerate

    // ==========================================================
    // timer inputs from pin five
    // both timers see the pin at once; which one uses it is the timers' choice
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timer1_clk_in  <= 1'b0;
            timer3_gate_in <= 1'b0;
        end
        else
        begin
            timer1_clk_in  <= pa_sync[`BIT_TIMER_PIN];
            timer3_gate_in <= pa_sync[`BIT_TIMER_PIN];
        end
    end

    // ==========================================================
    // open-drain enables per peripheral channel
    assign od_en[`CH_SERIAL1]  = od_serial_capture_q[`BIT_SERIAL1_OD];
    assign od_en[`CH_CAPTURE2] = od_serial_capture_q[`BIT_CAPTURE2_OD];
    assign od_en[`CH_CAPTURE1] = od_serial_capture_q[`BIT_CAPTURE1_OD];
    assign od_en[`CH_SERIAL2]  = od_serial_capture_q[`BIT_SERIAL2_OD];
    assign od_en[`CH_UART1]    = od_uart_pulse_q[`BIT_UART1_OD];
    assign od_en[`CH_UART2]    = od_uart_pulse_q[`BIT_UART2_OD];

    // capture units three to ten sit on consecutive channels
    generate
        for (u = 0; u < 8; u = u + 1)
        begin : g_capture_od
            assign od_en[`CH_CAPTURE3 + u] = od_capture_units_q[u];
        end
    endgenerate

    // ==========================================================
    // peripheral pads and pulse-delay input
    genvar c;
    generate
        for (c = 0; c < `NUM_PERIPH_CH; c = c + 1)
        begin : g_pad
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    periph_pad_out[c]  <= 1'b0;
                    periph_pad_oe_n[c] <= 1'b1;
                end
                else if (od_en[c])
                begin
                    // low is driven, high is left to the external pull-up
                    periph_pad_out[c]  <= 1'b0;
                    periph_pad_oe_n[c] <= ~(periph_drive[c] & ~periph_data[c]);
                end
                else
                begin
                    periph_pad_out[c]  <= periph_data[c];
                    periph_pad_oe_n[c] <= ~periph_drive[c];
                end
            end
        end
    endgenerate

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pulse_delay_in <= 1'b0;
        end
        else
        begin
            pulse_delay_in <= pf1_sync & od_uart_pulse_q[`BIT_PULSE_DELAY_EN];
        end
    end

endmodule
`default_nettype wire

// [hdl/sync_bits.v]
/*
  two-flop synchroniser, one per bit.
  assumes inputs asynchronous to hclk; only the second flop is read outside.
*/
`timescale 1ns/10ps
`default_nettype none

module sync_bits #(
    parameter WIDTH = 1
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;

    // ==========================================================
    // per-bit stages
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg stage1_q;
            reg stage2_q;
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    stage1_q <= 1'b0;
                    stage2_q <= 1'b0;
                end
                else
                begin
                    stage1_q <= async_in[i];
                    stage2_q <= stage1_q;
                end
            end
            assign sync_out[i] = stage2_q;
        end
    endgenerate

endmodule
`default_nettype wire

// [shared/port_a_defs.vh]
/*
  constants for the port A and open-drain control block: register byte
  offsets, implemented-bit masks, reset values and peripheral channel order.
  assumes inclusion by bare name from the design files.
*/
`ifndef PORT_A_DEFS_VH
`define PORT_A_DEFS_VH

// ==========================================================
// register byte offsets
`define OFS_OD_SERIAL_CAPTURE    8'h00
`define OFS_OD_CAPTURE_UNITS     8'h04
`define OFS_OD_UART_PULSE_DELAY  8'h08
`define OFS_ANALOG_SELECT        8'h0c
`define OFS_PORT_A_PIN_LEVELS    8'h10
`define OFS_PORT_A_OUTPUT_LATCH  8'h14
`define OFS_PORT_A_DIRECTION     8'h18

// ==========================================================
// implemented bits
`define MASK_OD_SERIAL_CAPTURE   8'he1
`define MASK_OD_CAPTURE_FULL     8'hff
`define MASK_OD_CAPTURE_SMALL    8'h3f
`define MASK_OD_UART_PULSE_DELAY 8'hc1
`define MASK_ANALOG_CAPABLE      8'h2f
`define MASK_OSC_PINS            8'hc0

// ==========================================================
// field positions
`define BIT_SERIAL1_OD           7
`define BIT_CAPTURE2_OD          6
`define BIT_CAPTURE1_OD          5
`define BIT_SERIAL2_OD           0
`define BIT_UART2_OD             7
`define BIT_UART1_OD             6
`define BIT_PULSE_DELAY_EN       0
`define BIT_TIMER_PIN            5

// ==========================================================
// reset values
`define RST_OD                   8'h00
`define RST_ANALOG_SELECT        8'h2f
`define RST_DIRECTION            8'hff
`define RST_LATCH                8'h00

// ==========================================================
// peripheral pad channels
`define NUM_PERIPH_CH            14
`define CH_SERIAL1               0
`define CH_CAPTURE2              1
`define CH_CAPTURE1              2
`define CH_SERIAL2               3
`define CH_CAPTURE3              4
`define CH_UART1                 12
`define CH_UART2                 13

`endif

// [verif/pad_model.sv]
/*
  external circuitry on the port A pads.
  assumes oe_n low means the block drives the pad.
*/
`timescale 1ns/10ps
`default_nettype none
module pad_model (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] ext_level,
    output logic      [7:0] pin_level
);
    // released pads follow the outside circuit, never the last driven value
    assign pin_level = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule
`default_nettype wire

// [verif/port_a_ctrl_assertions.sv]
/*
  checker on the port_a_ctrl ports.
  assumes hready is fed back from hreadyout.
*/
`timescale 1ns/10ps
`default_nettype none
module port_a_ctrl_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        osc_internal_cfg,
    input wire logic [7:0]  port_a_pin_in,
    input wire logic [7:0]  port_a_pin_oe_n,
    input wire logic [7:0]  port_a_analog_sel,
    input wire logic        timer1_clk_in,
    input wire logic        timer3_gate_in,
    input wire logic        port_f_pin_one_in,
    input wire logic        pulse_delay_in,
    input wire logic [13:0] periph_data,
    input wire logic [13:0] periph_drive,
    input wire logic [13:0] periph_pad_out,
    input wire logic [13:0] periph_pad_oe_n
);
    // ==========================================
    // bus and pads
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_read_wait: assert property (
        hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (
        hsel && hready && htrans[1] && hwrite |=> hreadyout) else $error("write stalled");
    chk_low_driven: assert property (
        $past(hresetn) |-> ((periph_pad_oe_n | periph_pad_out)
        & $past(periph_drive & ~periph_data)) == 14'h0000) else $error("low not driven");
    // a pad never drives without a request, open-drain or not
    chk_idle_release: assert property (
        $past(hresetn) |-> (~periph_pad_oe_n & ~$past(periph_drive)) == 14'h0000)
        else $error("pad driven unasked");
    chk_osc_pins: assert property (
        !osc_internal_cfg |-> port_a_pin_oe_n[7:6] == 2'h3) else $error("osc pin driven");
    chk_analog_pins: assert property (
        (port_a_analog_sel & 8'hd0) == 8'h00) else $error("pin not analog capable");
    chk_timer_follow: assert property (
        port_a_pin_in[5] [*5] |-> timer1_clk_in && timer3_gate_in) else $error("timer in");
    chk_pulse_gate: assert property (
        !port_f_pin_one_in [*5] |-> !pulse_delay_in) else $error("pulse delay leak");
endmodule

bind port_a_ctrl port_a_ctrl_chk chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .osc_internal_cfg, .port_a_pin_in, .port_a_pin_oe_n,
    .port_a_analog_sel, .timer1_clk_in, .timer3_gate_in, .port_f_pin_one_in,
    .pulse_delay_in, .periph_data, .periph_drive, .periph_pad_out, .periph_pad_oe_n);
`default_nettype wire

// [verif/port_a_ctrl_tb.sv]
/*
  self-checking bench for port_a_ctrl over ahb-lite.
  assumes the single slave, hready taken from hreadyout.
*/
`timescale 1ns/10ps
`default_nettype none
module port_a_ctrl_tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, osc = 1'b0;
    logic        hready, hresp, pf = 1'b0, t1, t3, pdly;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_q, hrdata_s, rd_s_q;
    logic [7:0]  pin_in, pin_out, pin_oe_n, asel, ext = 8'hff;
    logic [13:0] pdata = 14'h0, pdrive = 14'h0, pout, poe_n;
    int          num_errors = 0, checked = 0, cycles = 0;

    port_a_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .osc_internal_cfg(osc),
        .port_a_pin_in(pin_in), .port_a_pin_out(pin_out), .port_a_pin_oe_n(pin_oe_n),
        .port_a_analog_sel(asel), .timer1_clk_in(t1), .timer3_gate_in(t3),
        .port_f_pin_one_in(pf), .pulse_delay_in(pdly), .periph_data(pdata),
        .periph_drive(pdrive), .periph_pad_out(pout), .periph_pad_oe_n(poe_n));
    pad_model pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext),
        .pin_level(pin_in));
    // small variant on the same bus, read back in parallel; its bus timing matches dut
    port_a_ctrl #(.SMALL_VARIANT(1)) dut_small (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(), .hrdata(hrdata_s), .hresp(), .osc_internal_cfg(osc),
        .port_a_pin_in(pin_in), .port_a_pin_out(), .port_a_pin_oe_n(), .port_a_analog_sel(),
        .timer1_clk_in(), .timer3_gate_in(), .port_f_pin_one_in(pf), .pulse_delay_in(),
        .periph_data(pdata), .periph_drive(pdrive), .periph_pad_out(), .periph_pad_oe_n());

    // ==========================================
    // clock, timeout, report
    initial
    begin
        forever
            #2.5 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    task test_done;
    begin
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // ==========================================
    // bus tasks
    // read right at the edge, outputs still show the pre-edge values the slave saw
    task wait_rdy;
    begin
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        rd_q   = hrdata;
        rd_s_q = hrdata_s;
    end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
    begin
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy;
    end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
    begin
        ahb(1'b0, a, 8'h00);
        chk(rd_q, {24'h0, e});
    end
    endtask
    task do_reset(input logic o);
    begin
        hresetn <= 1'b0;
        osc     <= o;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    end
    endtask

    // ==========================================
    // scenarios
    initial
    begin
        do_reset(1'b0);
        rdc(8'h00, 8'h00);
        rdc(8'h04, 8'h00);
        rdc(8'h08, 8'h00);
        rdc(8'h0c, 8'h2f);
        chk({24'h0, asel}, 32'h2f);
        chk({31'h0, hresp}, 32'h0);
        rdc(8'h10, 8'h10);
        rdc(8'h14, 8'h00);
        rdc(8'h18, 8'h3f);
        ahb(1'b1, 8'h00, 8'hff);
        rdc(8'h00, 8'he1);
        ahb(1'b1, 8'h04, 8'hff);
        rdc(8'h04, 8'hff);
        chk(rd_s_q, 32'h3f);
        ahb(1'b1, 8'h08, 8'hfe);
        rdc(8'h08, 8'hc0);
        ahb(1'b1, 8'h1c, 8'hff);
        rdc(8'h1c, 8'h00);
        ahb(1'b1, 8'h0c, 8'h00);
        repeat (2) @(posedge hclk);
        chk({24'h0, asel}, 32'h00);
        ahb(1'b1, 8'h10, 8'h5a);
        rdc(8'h14, 8'h1a);
        ahb(1'b1, 8'h18, 8'h00);
        ext <= 8'h00;
        repeat (4) @(posedge hclk);
        rdc(8'h10, 8'h1a);
        ahb(1'b1, 8'h18, 8'hff);
        ext <= 8'hf3;
        repeat (6) @(posedge hclk);
        rdc(8'h10, 8'h33);
        chk({30'h0, t1, t3}, 32'h3);
        ahb(1'b1, 8'h0c, 8'h2f);
        rdc(8'h10, 8'h10);
        ahb(1'b1, 8'h18, 8'h00);
        repeat (2) @(posedge hclk);
        chk({24'h0, pin_oe_n}, 32'hc0);
        ahb(1'b1, 8'h18, 8'hff);
        ahb(1'b1, 8'h00, 8'h80);
        pdrive <= 14'h3fff;
        pdata  <= 14'h0009;
        repeat (3) @(posedge hclk);
        chk({29'h0, poe_n[3], pout[3], poe_n[0]}, 32'h3);
        pdata <= 14'h0000;
        repeat (3) @(posedge hclk);
        chk({18'h0, poe_n}, 32'h0);
        pf <= 1'b1;
        ahb(1'b1, 8'h08, 8'h01);
        repeat (5) @(posedge hclk);
        chk({31'h0, pdly}, 32'h1);
        ahb(1'b1, 8'h08, 8'h00);
        repeat (3) @(posedge hclk);
        chk({31'h0, pdly}, 32'h0);
        do_reset(1'b1);
        rdc(8'h18, 8'hff);
        ext <= 8'h00;
        ahb(1'b1, 8'h14, 8'hc0);
        ahb(1'b1, 8'h18, 8'h3f);
        repeat (4) @(posedge hclk);
        rdc(8'h10, 8'hc0);
        test_done;
    end
endmodule
`default_nettype wire
